// ### shared/bfs_pkg.sv
// Purpose: constants and carriers for the buck fault and mode sequencer
// Assumes: 125 MHz aclk
// Notes: register offsets are byte addresses on an AXI4-Lite slave
package bfs_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned HICCUP_WAIT_NS = 128000;
  localparam int unsigned HICCUP_WAIT_CYC = HICCUP_WAIT_NS / (1000000000 / CLK_HZ);
  localparam int unsigned RAMP_SLOW_US = 1500;
  localparam int unsigned RAMP_FAST_US = 500;
  localparam int unsigned RAMP_SLOW_CYC = RAMP_SLOW_US * (CLK_HZ / 1000000);
  localparam int unsigned RAMP_FAST_CYC = RAMP_FAST_US * (CLK_HZ / 1000000);
  localparam int unsigned EN_DELAY_US = 1;
  localparam int unsigned EN_DELAY_CYC = EN_DELAY_US * (CLK_HZ / 1000000);
  localparam int unsigned PWM_FREQ_KHZ = 1200;
  localparam int unsigned PWM_PERIOD_CYC = (CLK_HZ / 1000) / PWM_FREQ_KHZ;
  localparam int unsigned PFM_BASE_NS = 833;
  localparam int unsigned PFM_BASE_CYC = PFM_BASE_NS / (1000000000 / CLK_HZ);
  localparam logic [5:0] TRIP_LIMIT = 6'h20;
  // ==========================================================
  // registers
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CTRL_SWEN = 0;
  localparam int CTRL_HICCUP = 1;
  localparam int CTRL_FORCED_PWM_OPERATION = 2;
  localparam int STAT_UV = 0;
  localparam int STAT_LATCH = 1;
  localparam int STAT_PFM = 2;
  localparam int STAT_RUN = 3;
  localparam logic [2:0] CTRL_RESET = 3'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic uv;
    logic por_low;
    logic hot;
    logic en_pin;
    logic mode_pin;
    logic hs_limit;
    logic ls_limit;
    logic il_zero;
    logic near_dropout;
    logic ss_open;
    logic slow_variant;
    logic [7:0] duty_ratio;
  } bfs_sense_t;
  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic discharge;
    logic ss_pull;
    logic ramp_active;
    logic prebias_start;
  } bfs_drive_t;
endpackage

// ### rtl/bfs_regs.sv
// Purpose: two-word register store for the sequencer
// Assumes: writes single-word, read data registered
// Notes: brownout reset returns the control bits to their reset value; read data is kept
module bfs_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic brown_rst,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_strb,
  input wire logic [2:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic rd_sel_stat,
  input wire logic [3:0] stat_in,
  output logic [31:0] rd_data_q,
  // control out
  output logic [2:0] ctrl_q
);
  logic [2:0] ctrl_d;
  logic [31:0] rd_data_d;

  always_comb begin
    ctrl_d = ctrl_q;
    rd_data_d = rd_data_q;
    if (wr_en && wr_strb[0]) begin
      ctrl_d = wr_data;
    end
    if (rd_en) begin
      rd_data_d = rd_sel_stat ? {28'h0000000, stat_in} : {29'h00000000, ctrl_q};
    end
    // [R12] brownout register reset
    if (brown_rst) begin
      ctrl_d = bfs_pkg::CTRL_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= bfs_pkg::CTRL_RESET;
      rd_data_q <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      rd_data_q <= rd_data_d;
    end
  end
endmodule // bfs_regs

// ### rtl/bfs_sequencer.sv
// Purpose: start-up, mode and fault sequencer of a step-down converter
// Assumes: sense inputs synchronous to aclk; AXI4-Lite master well behaved
// Notes: analog loop and power-good are outside this block
// Notes on behaviour
// [R1] stop switching after 32 high-side trips
// [R2] auto-retry waits 128us then soft-starts
// [R3] auto-retry bit zero makes stop latching
// [R4] enable toggle, power, software write unlatch
// [R5] trip forces low side until low limit
// [R6] mode pin read only after ramp
// [R7] forced PWM register bit forces PWM
// [R8] enable delay then 1.5ms or 500us ramp
// [R9] off states pull soft-start, restart fully
// [R10] lockout stops, discharges, resumes via soft-start
// [R11] undervoltage status flag set on lockout
// [R12] below 1.8V all registers reset; code resets only the control bits, read data is kept
// [R13] zero inductor current enters power save
// [R14] power-save on-time is ratio times 833ns
// [R15] PWM period from 1.2MHz
// [R16] near dropout hold high side on
// [R17] ramp starts from prebiased output
// [R18] thermal stop keeps registers, soft-start resume
// [R19] trip count cleared each new start
// [R20] mode pin ignored during start-up
module bfs_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power stage
  input wire bfs_pkg::bfs_sense_t sense,
  output bfs_pkg::bfs_drive_t drive_q
);
  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_RAMP, ST_RUN, ST_HICCUP, ST_LATCHED
  } bfs_state_t;

  // ==========================================================
  // bus slave
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic wr_fire, rd_fire, wr_ctrl, rd_ok;
  logic [2:0] ctrl;
  logic [31:0] rd_data;
  logic [3:0] stat;

  function automatic logic addr_hit(input logic [3:0] a);
    addr_hit = (a == bfs_pkg::REG_CTRL) || (a == bfs_pkg::REG_STAT);
  endfunction

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      wr_fire = 1'b1;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_hit(awaddr_q) ? bfs_pkg::RESP_OKAY : bfs_pkg::RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rd_fire = 1'b1;
      rvalid_d = 1'b1;
      rresp_d = addr_hit(s_axi_araddr) ? bfs_pkg::RESP_OKAY : bfs_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  assign wr_ctrl = wr_fire && (awaddr_q == bfs_pkg::REG_CTRL);
  assign rd_ok = rd_fire && addr_hit(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rd_data;

  bfs_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .brown_rst(sense.por_low),
    .wr_en(wr_ctrl),
    .wr_strb(wstrb_q),
    .wr_data(wdata_q[2:0]),
    .rd_en(rd_ok),
    .rd_sel_stat(s_axi_araddr == bfs_pkg::REG_STAT),
    .stat_in(stat),
    .rd_data_q(rd_data),
    .ctrl_q(ctrl)
  );

  // ==========================================================
  // sequencer
  bfs_state_t st_q, st_d;
  logic [17:0] cnt_q, cnt_d;
  logic [5:0] trips_q, trips_d;
  logic en_q, en_d, uv_flag_q, uv_flag_d, forced_pwm_operation_q, forced_pwm_operation_d, pfm_q, pfm_d;
  logic limit_q, limit_d;
  logic [7:0] pcnt_q, pcnt_d;
  logic [15:0] ton_cyc;
  logic off_cond, sw_unlatch, pin_toggle, ramp_done;
  bfs_pkg::bfs_drive_t drive_d;

  assign off_cond = !sense.en_pin || sense.uv || sense.hot || sense.por_low;
  // unlatch needs the software enable bit set in the written word
  assign sw_unlatch = wr_ctrl && wdata_q[bfs_pkg::CTRL_SWEN];
  assign pin_toggle = sense.en_pin != en_q;
  assign ramp_done = cnt_q >= (sense.slow_variant ? 18'(bfs_pkg::RAMP_SLOW_CYC)
                                                  : 18'(bfs_pkg::RAMP_FAST_CYC));
  assign ton_cyc = (16'(sense.duty_ratio) * 16'(bfs_pkg::PFM_BASE_CYC)) >> 8;
  assign stat = {st_q == ST_RUN, pfm_q, st_q == ST_LATCHED, uv_flag_q};

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 18'h00001;
    trips_d = trips_q;
    en_d = sense.en_pin;
    uv_flag_d = uv_flag_q;
    forced_pwm_operation_d = forced_pwm_operation_q;
    pfm_d = pfm_q;
    limit_d = limit_q;
    pcnt_d = pcnt_q + 8'h01;
    drive_d = '0;
    // [R11] undervoltage flag, set wins
    if (sense.uv) begin
      uv_flag_d = 1'b1;
    end else if (wr_fire && awaddr_q == bfs_pkg::REG_STAT) begin
      uv_flag_d = 1'b0;
    end
    // [R9] off states restart fully
    if (off_cond || !ctrl[bfs_pkg::CTRL_SWEN]) begin
      st_d = ST_OFF;
      // [R10] discharge during lockout
      drive_d.discharge = 1'b1;
      drive_d.ss_pull = 1'b1;
    end else begin
      case (st_q)
        ST_OFF: begin
          st_d = ST_DELAY;
          cnt_d = '0;
          // [R19] fresh trip count
          trips_d = '0;
        end
        ST_DELAY: begin
          // [R8] enable delay
          if (cnt_q >= 18'(bfs_pkg::EN_DELAY_CYC)) begin
            st_d = ST_RAMP;
            cnt_d = '0;
          end
        end
        ST_RAMP: begin
          drive_d.ramp_active = 1'b1;
          // [R17] ramp from prebias
          drive_d.prebias_start = 1'b1;
          if (ramp_done) begin
            st_d = ST_RUN;
            // [R6] mode pin sampled after ramp
            forced_pwm_operation_d = sense.mode_pin;
          end
        end
        ST_RUN: begin
          // [R20] mode pin only once running
          forced_pwm_operation_d = sense.mode_pin;
        end
        ST_HICCUP: begin
          // [R2] retry wait
          if (cnt_q >= 18'(bfs_pkg::HICCUP_WAIT_CYC)) begin
            st_d = ST_DELAY;
            cnt_d = '0;
            trips_d = '0;
          end
        end
        ST_LATCHED: begin
          // [R4] unlatch events
          if (pin_toggle || sw_unlatch) begin
            st_d = ST_OFF;
          end
        end
        default: st_d = ST_OFF;
      endcase
      if (st_q == ST_RAMP || st_q == ST_RUN) begin
        // [R5] current limit cycle by cycle
        if (sense.hs_limit && !limit_q) begin
          limit_d = 1'b1;
          trips_d = trips_q + 6'h01;
          // [R1] trip count reached
          if (trips_q + 6'h01 == bfs_pkg::TRIP_LIMIT) begin
            // [R3] latching when retry disabled
            st_d = ctrl[bfs_pkg::CTRL_HICCUP] ? ST_HICCUP : ST_LATCHED;
            cnt_d = '0;
          end
        end else if (limit_q && sense.ls_limit) begin
          limit_d = 1'b0;
        end
        // [R7] register forces PWM
        if (ctrl[bfs_pkg::CTRL_FORCED_PWM_OPERATION] || forced_pwm_operation_q) begin
          pfm_d = 1'b0;
        // [R13] enter power save at zero current
        end else if (sense.il_zero) begin
          pfm_d = 1'b1;
        end else if (!sense.il_zero && pcnt_q == 8'h00) begin
          pfm_d = 1'b0;
        end
        if (pcnt_q >= 8'(bfs_pkg::PWM_PERIOD_CYC - 1)) begin
          pcnt_d = 8'h00;
        end
        if (limit_q || limit_d) begin
          drive_d.ls_on = 1'b1;
        // [R16] full duty in dropout
        end else if (sense.near_dropout) begin
          drive_d.hs_on = 1'b1;
        // [R14] fixed on-time in power save
        end else if (pfm_q) begin
          drive_d.hs_on = {8'h00, pcnt_q} < ton_cyc;
          drive_d.ls_on = !drive_d.hs_on && !sense.il_zero;
        // [R15] pwm period
        end else begin
          drive_d.hs_on = pcnt_q < sense.duty_ratio[7:1];
          drive_d.ls_on = !drive_d.hs_on;
        end
        if (st_d != st_q && st_d != ST_RUN) begin
          // low side kept for the stopping cycle, the limit still holds
          drive_d.hs_on = 1'b0;
        end
      end
    end
    // [R18] thermal stop keeps ctrl; only brownout, aresetn or a control write changes it
    if (sense.hot) begin
      drive_d.discharge = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_OFF;
      cnt_q <= '0;
      trips_q <= '0;
      en_q <= 1'b0;
      uv_flag_q <= 1'b0;
      forced_pwm_operation_q <= 1'b0;
      pfm_q <= 1'b0;
      limit_q <= 1'b0;
      pcnt_q <= 8'h00;
      drive_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      trips_q <= trips_d;
      en_q <= en_d;
      uv_flag_q <= uv_flag_d;
      forced_pwm_operation_q <= forced_pwm_operation_d;
      pfm_q <= pfm_d;
      limit_q <= limit_d;
      pcnt_q <= pcnt_d;
      drive_q <= drive_d;
    end
  end
endmodule // bfs_sequencer

// ### testbench/bfs_seq_sva.sv
// Purpose: port-level checks of the sequencer
// Assumes: one aclk domain, sync active-low reset
// Notes: ramp length only judged when not cut by a fault
module bfs_seq_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // power stage
  input wire bfs_pkg::bfs_sense_t sense,
  input wire bfs_pkg::bfs_drive_t drive_q
);
  // ==========================================================
  // helper counters
  localparam int RMIN = bfs_pkg::RAMP_FAST_CYC - 4;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [17:0] idle_q, idle_d, ramp_q, ramp_d;
  logic cut_q, cut_d;
  always_comb begin
    idle_d = (drive_q.hs_on || drive_q.ls_on || drive_q.ramp_active) ? 18'h0 : idle_q + 18'h1;
    ramp_d = drive_q.ramp_active ? ramp_q + 18'h1 : 18'h0;
    // a ramp that saw any high-side trip flag is a fault stop, not a short ramp
    cut_d = drive_q.ramp_active && (cut_q || sense.hs_limit);
  end
  always_ff @(posedge aclk) begin
    idle_q <= aresetn ? idle_d : 18'h0;
    ramp_q <= aresetn ? ramp_d : 18'h0;
    cut_q <= aresetn ? cut_d : 1'b0;
  end
  a_trip_low_side: assert property (
    $rose(sense.hs_limit) && drive_q.hs_on |-> ##[1:2] (drive_q.ls_on && !drive_q.hs_on))
    else $error("low side not taken after trip");
  a_no_shoot: assert property (!(drive_q.hs_on && drive_q.ls_on))
    else $error("both switches on");
  a_uv_stops: assert property (
    sense.uv |-> ##[1:2] (drive_q.discharge && !drive_q.hs_on && !drive_q.ls_on))
    else $error("lockout did not stop");
  a_hot_stops: assert property (
    sense.hot |-> ##[1:2] (drive_q.discharge && !drive_q.hs_on && !drive_q.ls_on))
    else $error("thermal stop missing");
  a_off_pulls_ss: assert property (
    !sense.en_pin ##1 !sense.en_pin |=> drive_q.ss_pull)
    else $error("soft-start not pulled");
  a_delay_first: assert property ($rose(drive_q.ramp_active) |-> idle_q >= 18'h64)
    else $error("ramp without enable delay");
  a_ramp_length: assert property (
    $fell(drive_q.ramp_active) && !drive_q.discharge && !drive_q.ss_pull && !cut_q
    |-> ramp_q >= RMIN)
    else $error("ramp too short");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  c_ramp_done: cover property ($fell(drive_q.ramp_active));
  c_trip: cover property ($rose(sense.hs_limit) && drive_q.hs_on);
  c_uv: cover property (sense.uv && drive_q.discharge);
endmodule // bfs_seq_sva

bind bfs_sequencer bfs_seq_sva u_bfs_seq_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .sense(sense), .drive_q(drive_q));

// ### testbench/bfs_stage_model.sv
// Purpose: power stage stand-in giving current-limit flags
// Assumes: flags synchronous to aclk
// Notes: overload raises the high-side flag two cycles in eight, one trip per eight cycles, not kinder when off
module bfs_stage_model (
  // clock
  input wire logic aclk,
  // control and switches
  input wire logic overload,
  input wire bfs_pkg::bfs_drive_t drive_q,
  // sensed flags
  output logic hs_limit,
  output logic ls_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // current model
  logic [2:0] ph_q = 3'h0;
  logic [1:0] ls_q = 2'h0;
  initial hs_limit = 1'b0;
  initial ls_limit = 1'b0;
  always @(posedge aclk) begin
    ph_q <= ph_q + 3'h1;
    hs_limit <= overload && !drive_q.ls_on && (ph_q < 3'h2);
    // low side current decays to limit
    ls_q <= drive_q.ls_on ? ls_q + 2'h1 : 2'h0;
    ls_limit <= drive_q.ls_on && (ls_q == 2'h3);
  end
endmodule // bfs_stage_model

// ### testbench/test_buck_fault_mode_sequencer.sv
// Purpose: self-checking bench of the sequencer
// Assumes: 125 MHz aclk, fast ramp variant
// Notes: only one full ramp is timed, to keep the run short
module test_buck_fault_mode_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic aclk = 1'b0, aresetn = 1'b0, ovl = 1'b0, hs_lim, ls_lim;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  bfs_pkg::bfs_sense_t sen, sense;
  bfs_pkg::bfs_drive_t drv;
  int n_fail = 0, comparisons = 0, cyc = 0, n;
  always_comb begin
    sense = sen;
    sense.hs_limit = hs_lim;
    sense.ls_limit = ls_lim;
  end
  bfs_sequencer u_bfs_sequencer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sense(sense),
    .drive_q(drv));
  bfs_stage_model u_bfs_stage_model (.aclk(aclk), .overload(ovl), .drive_q(drv),
    .hs_limit(hs_lim), .ls_limit(ls_lim));
  initial forever #4 aclk = ~aclk;
  // hang guard above the expected 97k cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 99000) begin
      n_fail++;
      results();
    end
  end
  // ==========================================================
  // tasks
  task automatic results;
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  function automatic logic [31:0] exp_ctrl(input logic [2:0] c);
    return {29'h0, c};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      aw = aw || (awready && awvalid);
      w = w || (wready && wvalid);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!(aw && w));
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_ramp;
    n = 0;
    while (!drv.ramp_active && n < 400) begin
      @(posedge aclk);
      n++;
    end
  endtask
  // ==========================================================
  // sequence
  initial begin
    sen = '0;
    sen.en_pin = 1'b1;
    sen.ss_open = 1'b1;
    sen.mode_pin = 1'b1;
    sen.il_zero = 1'b1;
    void'($urandom(18));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    sen.duty_ratio <= 8'($urandom);
    repeat (2) @(posedge aclk);
    rdr(bfs_pkg::REG_CTRL);
    chk_word("ctrl reset", exp_ctrl(bfs_pkg::CTRL_RESET), rd);
    rdr(4'h8);
    chk_word("read resp", {30'h0, bfs_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(4'hc, 32'h0);
    chk_word("write resp", {30'h0, bfs_pkg::RESP_SLVERR}, {30'h0, rs});
    while (!drv.ramp_active) @(posedge aclk);
    n = 0;
    while (drv.ramp_active) begin
      @(posedge aclk);
      n++;
    end
    chk_bit("ramp len", 1'b1, n >= bfs_pkg::RAMP_FAST_CYC - 2 && n <= bfs_pkg::RAMP_FAST_CYC + 2);
    for (int i = 0; i < 3; i++) begin
      sen.mode_pin <= (i == 1);
      wr(bfs_pkg::REG_CTRL, (i == 2) ? 32'h7 : 32'h3);
      rdr(bfs_pkg::REG_STAT);
      chk_bit("running", 1'b1, rd[bfs_pkg::STAT_RUN]);
      chk_bit("power save", i == 0, rd[bfs_pkg::STAT_PFM]);
    end
    sen.near_dropout <= 1'b1;
    repeat (3) @(posedge aclk);
    chk_bit("dropout hs", 1'b1, drv.hs_on && !drv.ls_on);
    sen.near_dropout <= 1'b0;
    wr(bfs_pkg::REG_CTRL, 32'h3);
    ovl <= 1'b1;
    repeat (400) @(posedge aclk);
    chk_bit("hs in retry", 1'b0, drv.hs_on);
    ovl <= 1'b0;
    repeat (15800) @(posedge aclk);
    chk_bit("retry pause", 1'b0, drv.ramp_active);
    wait_ramp();
    chk_bit("retry ramp", 1'b1, drv.ramp_active);
    wr(bfs_pkg::REG_CTRL, 32'h1);
    ovl <= 1'b1;
    repeat (400) @(posedge aclk);
    chk_bit("hs after trips", 1'b0, drv.hs_on);
    ovl <= 1'b0;
    // longer than the retry pause, so a retry would show
    repeat (16200 + $urandom_range(63)) @(posedge aclk);
    chk_bit("no retry", 1'b0, drv.ramp_active);
    rdr(bfs_pkg::REG_STAT);
    chk_bit("latched", 1'b1, rd[bfs_pkg::STAT_LATCH]);
    wr(bfs_pkg::REG_CTRL, 32'h3);
    wait_ramp();
    chk_bit("unlatch ramp", 1'b1, drv.ramp_active);
    chk_bit("prebias ramp", 1'b1, drv.prebias_start);
    wr(bfs_pkg::REG_CTRL, 32'h1);
    ovl <= 1'b1;
    repeat (400) @(posedge aclk);
    ovl <= 1'b0;
    chk_bit("relatched", 1'b0, drv.ramp_active);
    sen.en_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    chk_bit("en off pull", 1'b1, drv.ss_pull && drv.discharge);
    sen.en_pin <= 1'b1;
    wait_ramp();
    chk_bit("pin unlatch", 1'b1, drv.ramp_active);
    sen.uv <= 1'b1;
    repeat (20) @(posedge aclk);
    chk_bit("uv stop", 1'b1, drv.discharge && drv.ss_pull && !drv.hs_on);
    sen.uv <= 1'b0;
    rdr(bfs_pkg::REG_STAT);
    chk_bit("uv flag", 1'b1, rd[bfs_pkg::STAT_UV]);
    wr(bfs_pkg::REG_STAT, 32'h0);
    rdr(bfs_pkg::REG_STAT);
    chk_bit("uv cleared", 1'b0, rd[bfs_pkg::STAT_UV]);
    wait_ramp();
    chk_bit("uv resume", 1'b1, drv.ramp_active);
    wr(bfs_pkg::REG_CTRL, 32'h7);
    sen.hot <= 1'b1;
    repeat (8) @(posedge aclk);
    chk_bit("hot stop", 1'b1, drv.discharge);
    rdr(bfs_pkg::REG_CTRL);
    chk_word("ctrl kept", exp_ctrl(3'h7), rd);
    sen.hot <= 1'b0;
    sen.por_low <= 1'b1;
    repeat (8) @(posedge aclk);
    sen.por_low <= 1'b0;
    rdr(bfs_pkg::REG_CTRL);
    chk_word("ctrl brownout", exp_ctrl(bfs_pkg::CTRL_RESET), rd);
    results();
  end
endmodule // test_buck_fault_mode_sequencer
